// ### bench/board_model.sv
`timescale 1ns/100ps
// ============================================================
// Board side of the six pads
// Each pad shows the device level while the device drives it.
// Otherwise it shows what the outside world puts on it. No pull
// is modelled, so a released pad never keeps the device's value.
module board_model (
  input wire logic [5:0] pad_out_i,
  input wire logic [5:0] pad_oe_i,
  input wire logic [5:0] ext_level_i,
  output logic [5:0] pad_in_o
);
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pad_in_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_level_i[i];
    end
  end
endmodule // board_model

// ### bench/tb_top.sv
`timescale 1ns/100ps
`define CHK(what, exp, act) begin samples_checked++; if ((act) !== (exp)) begin errors++; \
  $display("mismatch %s expected %h seen %h", what, exp, act); end end
module tb_top;
  import port_g_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [5:0] port_data = 6'h15;
  logic [5:0] input_enable = 6'h3c;
  logic [5:0] ext_level = 6'h0c;
  logic [5:0] port_in, pad_in, pad_out, pad_oe;
  logic int_one, int_zero;
  serial_drive_t serial_drive = 6'b110111;
  serial_sense_t serial_sense;
  logic [4:0] address_line = 5'h16;
  capture_t capture;
  int errors = 0;
  int samples_checked = 0;
  logic [5:0] offsets [4] = '{6'h04, 6'h08, 6'h0c, 6'h10};
  logic [5:0] masks [4] = '{6'h3f, 6'h2f, 6'h1f, 6'h1e};

  always #20 clock = ~clock;

  port_g_output_and_function_select i_port_g_output_and_function_select (
    .clock_i(clock), .rst_n_i(rst_n), .ce_i(ce), .address_i(address), .read_i(read),
    .write_i(write), .writedata_i(writedata), .byteenable_i(byteenable),
    .readdata_o(readdata), .waitrequest_o(waitrequest), .port_data_i(port_data),
    .input_enable_i(input_enable), .port_in_o(port_in), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .external_interrupt_one_o(int_one),
    .external_interrupt_zero_o(int_zero), .serial_drive_i(serial_drive),
    .serial_sense_o(serial_sense), .address_line_i(address_line), .capture_o(capture));
  board_model i_board_model (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .ext_level_i(ext_level), .pad_in_o(pad_in));

  task automatic report_and_stop();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Waitrequest and read data are read right after the edge, before that edge's updates land.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    address <= a; writedata <= d; byteenable <= be; write <= wr; read <= !wr;
    do begin @(posedge clock); n++; end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    if (n >= 50) begin errors++; report_and_stop(); end
    read <= 1'b0; write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] rd;
    bus(1'b1, a, d, be, rd);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, 4'hf, rd);
    `CHK("readdata", exp, rd)
  endtask

  task automatic t_registers();
    for (int i = 0; i < 4; i++) begin
      rd_chk(offsets[i], 32'h0);
      wr(offsets[i], 32'hffff_ffff);
      rd_chk(offsets[i], {26'h0, masks[i]});
      wr(offsets[i], 32'h0, 4'he);
      rd_chk(offsets[i], {26'h0, masks[i]});
      wr(offsets[i], 32'h0);
      rd_chk(offsets[i], 32'h0);
    end
    wr(6'h00, 32'hffff_ffff);
    rd_chk(6'h00, 32'h0);
    wr(6'h14, 32'hffff_ffff);
    rd_chk(6'h14, 32'h0);
  endtask

  task automatic t_port_mode();
    wr(6'h04, 32'h2a);
    @(negedge clock);
    `CHK("pad_oe", 6'h2a, pad_oe)
    `CHK("pad_out", port_data & 6'h2a, pad_out & 6'h2a)
    `CHK("port_in", ((port_data & 6'h2a) | (ext_level & ~6'h2a)) & input_enable, port_in)
    @(posedge clock);
    wr(6'h04, 32'h0);
  endtask

  // Each pin has at most one function bit set at any time.
  task automatic t_function_one();
    ext_level <= 6'h28;
    input_enable <= 6'h3f;
    wr(6'h08, 32'h2f);
    @(negedge clock);
    `CHK("pad_oe", 6'h07, pad_oe)
    `CHK("pad_out", 3'b101, pad_out[2:0])
    `CHK("int_one", 1'b1, int_one)
    `CHK("int_zero", 1'b1, int_zero)
    `CHK("serial_sense", 3'b101, serial_sense)
    @(posedge clock);
    ext_level <= 6'h20;
    @(negedge clock);
    `CHK("int_zero", 1'b0, int_zero)
    @(posedge clock);
    wr(6'h08, 32'h0);
  endtask

  task automatic t_function_two();
    wr(6'h0c, 32'h1f);
    @(negedge clock);
    `CHK("pad_oe", 6'h1f, pad_oe)
    `CHK("pad_out", address_line, pad_out[4:0])
    @(posedge clock);
    wr(6'h0c, 32'h0);
  endtask

  task automatic t_function_three();
    ext_level <= 6'h14;
    wr(6'h10, 32'h1e);
    @(negedge clock);
    `CHK("pad_oe", 6'h00, pad_oe)
    `CHK("capture", 4'ha, capture)
    `CHK("serial_sense", 3'b000, serial_sense)
    @(posedge clock);
    wr(6'h10, 32'h0);
  endtask

  // A frozen block must neither answer the bus nor take the write.
  task automatic t_clock_enable();
    ce <= 1'b0;
    fork
      wr(6'h04, 32'h3f);
      begin
        repeat (4) @(posedge clock);
        `CHK("waitrequest", 1'b1, waitrequest)
        `CHK("pad_oe", 6'h00, pad_oe)
        ce <= 1'b1;
      end
    join
    @(negedge clock);
    `CHK("pad_oe", 6'h3f, pad_oe)
    @(posedge clock);
    wr(6'h04, 32'h0);
  endtask

  // A reset in mid-run must bring every pin back to a plain, undriven port pin.
  task automatic t_reset_midrun();
    wr(6'h04, 32'h3f);
    wr(6'h08, 32'h2f);
    rst_n <= 1'b0;
    @(negedge clock);
    `CHK("pad_oe", 6'h00, pad_oe)
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_chk(6'h04, 32'h0);
    rd_chk(6'h08, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge clock);
    `CHK("pad_oe", 6'h00, pad_oe)
    rst_n <= 1'b1;
    @(posedge clock);
    t_registers();
    t_port_mode();
    t_function_one();
    t_function_two();
    t_function_three();
    t_clock_enable();
    t_reset_midrun();
    report_and_stop();
  end
endmodule // tb_top

// ### hw/pin_route.sv
`timescale 1ns/100ps
module pin_route #(
  parameter int N_ALT = 3
) (
  input wire logic [N_ALT-1:0] select_i,
  input wire logic port_out_i,
  input wire logic port_oe_i,
  input wire logic [N_ALT-1:0] alt_out_i,
  input wire logic [N_ALT-1:0] alt_oe_i,
  input wire logic pad_in_i,
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic [N_ALT-1:0] alt_in_o
);

  // With more than one select bit set the alternates are OR-ed; software must avoid that.
  always_comb begin
    pad_out_o = 1'b0;
    pad_oe_o = 1'b0;
    if (select_i == '0) begin
      pad_out_o = port_out_i;
      pad_oe_o = port_oe_i;
    end else begin
      for (int k = 0; k < N_ALT; k++) begin
        pad_out_o = pad_out_o | (select_i[k] & alt_out_i[k]);
        pad_oe_o = pad_oe_o | (select_i[k] & alt_oe_i[k]);
      end
    end
    for (int k = 0; k < N_ALT; k++) begin
      alt_in_o[k] = select_i[k] & pad_in_i;
    end
  end

endmodule // pin_route

// ### hw/port_g_output_and_function_select.sv
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
// Behaviour
// - Output enable bits 5-0, reset zero, upper zero
// - Function one: interrupts, serial clock, serial lines
// - Function two: pins 4-0 become address 7-3
// - Function three: pins 4-1 feed timer captures
// - After reset all pins plain, drivers off
module port_g_output_and_function_select (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [5:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic [5:0] port_data_i,
  input wire logic [5:0] input_enable_i,
  output logic [5:0] port_in_o,
  input wire logic [5:0] pad_in_i,
  output logic [5:0] pad_out_o,
  output logic [5:0] pad_oe_o,
  output logic external_interrupt_one_o,
  output logic external_interrupt_zero_o,
  input wire port_g_pkg::serial_drive_t serial_drive_i,
  output port_g_pkg::serial_sense_t serial_sense_o,
  input wire logic [4:0] address_line_i,
  output port_g_pkg::capture_t capture_o
);
  import port_g_pkg::*;

  // ==========================================================
  // Register bus slave
  // ==========================================================
  port_state_t s;
  port_state_t next_s;
  logic request;
  logic [5:0] read_field;

  assign request = read_i | write_i;
  // Every access waits exactly one cycle while ce_i is high so read data can come from a flop.
  assign waitrequest_o = request & ~s.ack;
  assign readdata_o = s.read_data;

  always_comb begin
    case (address_i)
      OFS_OUTPUT_ENABLE: read_field = s.regs.output_enable;
      OFS_FUNCTION_ONE: read_field = s.regs.function_one;
      OFS_FUNCTION_TWO: read_field = s.regs.function_two;
      OFS_FUNCTION_THREE: read_field = s.regs.function_three;
      default: read_field = RESET_FIELD;
    endcase
  end

  always_comb begin
    next_s = s;
    if (request && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.read_data = {26'h0000000, read_field};
    end else begin
      next_s.ack = 1'b0;
      if (write_i && s.ack && byteenable_i[0]) begin
        case (address_i)
          OFS_OUTPUT_ENABLE: begin
            next_s.regs.output_enable = writedata_i[5:0] & MASK_OUTPUT_ENABLE;
          end
          OFS_FUNCTION_ONE: begin
            next_s.regs.function_one = writedata_i[5:0] & MASK_FUNCTION_ONE;
          end
          OFS_FUNCTION_TWO: begin
            next_s.regs.function_two = writedata_i[5:0] & MASK_FUNCTION_TWO;
          end
          OFS_FUNCTION_THREE: begin
            next_s.regs.function_three = writedata_i[5:0] & MASK_FUNCTION_THREE;
          end
          default: begin
            next_s.regs = s.regs;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s.regs.output_enable <= RESET_FIELD;
      s.regs.function_one <= RESET_FIELD;
      s.regs.function_two <= RESET_FIELD;
      s.regs.function_three <= RESET_FIELD;
      s.ack <= 1'b0;
      s.read_data <= RESET_READ_DATA;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Pin routing
  // ==========================================================
  // Alternate slot 0 is function one, 1 is function two, 2 is function three.
  logic [ALT_COUNT-1:0] alt_out [PIN_COUNT];
  logic [ALT_COUNT-1:0] alt_oe [PIN_COUNT];
  logic [ALT_COUNT-1:0] alt_in [PIN_COUNT];
  logic [5:0] gated_in;

  // Input path stays dead until the outside input enable opens it.
  assign gated_in = pad_in_i & input_enable_i;
  assign port_in_o = gated_in;

  always_comb begin
    for (int p = 0; p < PIN_COUNT; p++) begin
      alt_out[p] = '0;
      alt_oe[p] = '0;
    end
    alt_out[0][0] = serial_drive_i.bus_data_out;
    alt_oe[0][0] = serial_drive_i.bus_data_oe;
    alt_out[1][0] = serial_drive_i.bus_clock_out;
    alt_oe[1][0] = serial_drive_i.bus_clock_oe;
    alt_out[2][0] = serial_drive_i.clock_out;
    alt_oe[2][0] = serial_drive_i.clock_oe;
    for (int p = 0; p < 5; p++) begin
      alt_out[p][1] = address_line_i[p];
      alt_oe[p][1] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      // Overlapping selects are left to software; the router just merges them.
      pin_route #(
        .N_ALT(ALT_COUNT)
      ) u_route (
        .select_i({s.regs.function_three[g], s.regs.function_two[g], s.regs.function_one[g]}),
        .port_out_i(port_data_i[g]),
        .port_oe_i(s.regs.output_enable[g]),
        .alt_out_i(alt_out[g]),
        .alt_oe_i(alt_oe[g]),
        .pad_in_i(gated_in[g]),
        .pad_out_o(pad_out_o[g]),
        .pad_oe_o(pad_oe_o[g]),
        .alt_in_o(alt_in[g])
      );
    end
  endgenerate

  assign external_interrupt_one_o = alt_in[5][0];
  assign external_interrupt_zero_o = alt_in[3][0];
  assign serial_sense_o.serial_clock_zero = alt_in[2][0];
  assign serial_sense_o.bus_clock_or_serial_input_zero = alt_in[1][0];
  assign serial_sense_o.bus_data_or_serial_output_zero = alt_in[0][0];
  assign capture_o.timer4_capture_input_one = alt_in[4][2];
  assign capture_o.timer4_capture_input_zero = alt_in[3][2];
  assign capture_o.timer3_capture_input_one = alt_in[2][2];
  assign capture_o.timer3_capture_input_zero = alt_in[1][2];

  // ==========================================================
  // Assertions
  // ==========================================================
  logic write_done;
  logic read_done;
  assign write_done = ce_i & write_i & s.ack & byteenable_i[0];
  assign read_done = read_i & ~waitrequest_o;

  sequence s_write_to(logic [5:0] ofs);
    write_done && address_i == ofs;
  endsequence

  property p_oe_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_write_to(OFS_OUTPUT_ENABLE) |=> s.regs.output_enable == $past(writedata_i[5:0]);
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("output enable write lost");

  property p_read_upper_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
    read_done |-> readdata_o[31:6] == 26'h0000000;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits set");

  property p_f1_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_write_to(OFS_FUNCTION_ONE) |=>
      s.regs.function_one == ($past(writedata_i[5:0]) & 6'h2f);
  endproperty
  a_f1_write: assert property (p_f1_write) else $error("function one write wrong");

  property p_f2_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_write_to(OFS_FUNCTION_TWO) |=>
      s.regs.function_two == ($past(writedata_i[5:0]) & 6'h1f);
  endproperty
  a_f2_write: assert property (p_f2_write) else $error("function two write wrong");

  property p_f3_write;
    @(posedge clock_i) disable iff (!rst_n_i)
    s_write_to(OFS_FUNCTION_THREE) |=>
      s.regs.function_three == ($past(writedata_i[5:0]) & 6'h1e);
  endproperty
  a_f3_write: assert property (p_f3_write) else $error("function three write wrong");

  property p_reset_idle;
    @(posedge clock_i)
    $rose(rst_n_i) |-> pad_oe_o == 6'h00 && port_in_o == (pad_in_i & input_enable_i);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pin driven after reset");

  property p_alt_owns_pin;
    @(posedge clock_i) disable iff (!rst_n_i)
    (s.regs.function_two[0] && !s.regs.function_one[0] && !s.regs.function_three[0])
      |-> pad_oe_o[0] && pad_out_o[0] == address_line_i[0];
  endproperty
  a_alt_owns_pin: assert property (p_alt_owns_pin) else $error("pin 0 not on address");

  property p_one_wait;
    @(posedge clock_i) disable iff (!rst_n_i)
    (request && !s.ack && ce_i) |=> (request -> !waitrequest_o);
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");

endmodule // port_g_output_and_function_select

// ### pkg/port_g_pkg.sv
package port_g_pkg;

  localparam int PIN_COUNT = 6;
  localparam int ALT_COUNT = 3;

  // Byte addresses of the control registers on the register bus.
  localparam logic [5:0] OFS_OUTPUT_ENABLE = 6'h04;
  localparam logic [5:0] OFS_FUNCTION_ONE = 6'h08;
  localparam logic [5:0] OFS_FUNCTION_TWO = 6'h0c;
  localparam logic [5:0] OFS_FUNCTION_THREE = 6'h10;

  // Writable bits of each register; everything else reads as zero.
  localparam logic [5:0] MASK_OUTPUT_ENABLE = 6'h3f;
  localparam logic [5:0] MASK_FUNCTION_ONE = 6'h2f;
  localparam logic [5:0] MASK_FUNCTION_TWO = 6'h1f;
  localparam logic [5:0] MASK_FUNCTION_THREE = 6'h1e;

  localparam logic [5:0] RESET_FIELD = 6'h00;
  localparam logic [31:0] RESET_READ_DATA = 32'h0000_0000;

  typedef struct packed {
    logic [5:0] output_enable;
    logic [5:0] function_one;
    logic [5:0] function_two;
    logic [5:0] function_three;
  } port_regs_t;

  typedef struct packed {
    port_regs_t regs;
    logic ack;
    logic [31:0] read_data;
  } port_state_t;

  // Serial channel 0 as seen from the peripheral side.
  typedef struct packed {
    logic clock_out;
    logic clock_oe;
    logic bus_clock_out;
    logic bus_clock_oe;
    logic bus_data_out;
    logic bus_data_oe;
  } serial_drive_t;

  typedef struct packed {
    logic serial_clock_zero;
    logic bus_clock_or_serial_input_zero;
    logic bus_data_or_serial_output_zero;
  } serial_sense_t;

  typedef struct packed {
    logic timer4_capture_input_one;
    logic timer4_capture_input_zero;
    logic timer3_capture_input_one;
    logic timer3_capture_input_zero;
  } capture_t;

endpackage
